// ### pkg/ebio_pkg.sv
package ebio_pkg;

    // ------------------------------------------------------------
    // register window
    // ------------------------------------------------------------
    localparam logic [31:0] BASE_ADDR = 32'h400C_0900;
    localparam int WIN_MSB = 5;
    localparam logic [5:0] OFF_DATA = 6'h00;
    localparam logic [5:0] OFF_OE = 6'h04;
    localparam logic [5:0] OFF_FR2 = 6'h0C;
    localparam logic [5:0] OFF_FR3 = 6'h10;
    localparam logic [5:0] OFF_PU = 6'h2C;
    localparam logic [5:0] OFF_IE = 6'h38;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int PORT_W = 8;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_OE = 8'h00;
    localparam logic [7:0] RST_FR2 = 8'h00;
    localparam logic [7:0] RST_FR3 = 8'h00;
    localparam logic [7:0] RST_PU = 8'h00;
    localparam logic [7:0] RST_IE = 8'h00;
    localparam logic [7:0] FR2_MASK = 8'h80;
    localparam logic [7:0] FR3_MASK = 8'hC0;
    localparam int IRQ_PIN = 7;
    localparam int TIN1_PIN = 7;
    localparam int TIN0_PIN = 6;

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        SEL_DATA, SEL_OE, SEL_FR2, SEL_FR3, SEL_PU, SEL_IE, SEL_RSVD, SEL_OUT
    } ebio_sel_t;

    // maps a byte address onto the register it selects
    function automatic ebio_sel_t ebio_decode(input logic [31:0] a);
        ebio_sel_t s;
        s = SEL_RSVD;
        if (a[31:WIN_MSB+1] != BASE_ADDR[31:WIN_MSB+1]) begin
            s = SEL_OUT;
        end else begin
            case (a[WIN_MSB:0])
                OFF_DATA: s = SEL_DATA;
                OFF_OE: s = SEL_OE;
                OFF_FR2: s = SEL_FR2;
                OFF_FR3: s = SEL_FR3;
                OFF_PU: s = SEL_PU;
                OFF_IE: s = SEL_IE;
                default: s = SEL_RSVD;
            endcase
        end
        return s;
    endfunction

endpackage

// ### pkg/ebio_cfg_if.sv
`timescale 1ns/1ps
interface ebio_cfg_if;
    logic [7:0] data;
    logic [7:0] oe;
    logic [7:0] pu;
    logic [7:0] ie;
    logic [7:0] fr2;
    logic [7:0] fr3;
    logic [7:0] level;
    logic stop;
    modport regs (output data, oe, pu, ie, fr2, fr3, stop, input level);
    modport drive (input data, oe, pu, ie);
    modport sense (input ie, fr2, fr3, stop, output level);
endinterface

// ### design/ebio_pin_drive.sv
`timescale 1ns/1ps
module ebio_pin_drive (
    input wire logic ref_clk,
    input wire logic reset,
    ebio_cfg_if.drive cfg,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_pullup,
    output logic [7:0] analog_ready
);
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
        logic [7:0] an;
    } ebio_drv_t;

    ebio_drv_t st;
    ebio_drv_t nx;

    // pad controls follow the registers one cycle later
    always_comb begin
        nx = st;
        nx.out = cfg.data;
        nx.oe = cfg.oe;
        nx.pu = cfg.pu;
        nx.an = ~cfg.ie & ~cfg.pu;
    end

    // state register, everything off after reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign pin_out = st.out;
    assign pin_oe = st.oe;
    assign pin_pullup = st.pu;
    assign analog_ready = st.an;
endmodule

// ### design/ebio_pin_sense.sv
`timescale 1ns/1ps
module ebio_pin_sense (
    input wire logic ref_clk,
    input wire logic reset,
    ebio_cfg_if.sense cfg,
    input wire logic [7:0] pin_in,
    output logic external_irq_nine,
    output logic timer_capture_in0,
    output logic timer_capture_in1
);
    typedef struct packed {
        logic [7:0] level;
        logic irq;
        logic tin0;
        logic tin1;
    } ebio_sns_t;

    ebio_sns_t st;
    ebio_sns_t nx;
    logic [7:0] buf_in;

    // disabled input buffers read as zero
    assign buf_in = pin_in & cfg.ie;

    // route buffered pins to peripheral inputs
    always_comb begin
        nx = st;
        nx.level = buf_in;
        // stop mode only passes the interrupt pin if it is routed as a wake source
        nx.irq = buf_in[ebio_pkg::IRQ_PIN]
            && (!cfg.stop || cfg.fr2[ebio_pkg::IRQ_PIN]);
        nx.tin1 = buf_in[ebio_pkg::TIN1_PIN]
            && cfg.fr3[ebio_pkg::TIN1_PIN];
        nx.tin0 = buf_in[ebio_pkg::TIN0_PIN]
            && cfg.fr3[ebio_pkg::TIN0_PIN];
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign cfg.level = st.level;
    assign external_irq_nine = st.irq;
    assign timer_capture_in0 = st.tin0;
    assign timer_capture_in1 = st.tin1;
endmodule

// ### design/ebio_port_j.sv
`timescale 1ns/1ps
module ebio_port_j (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic stop_mode,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_pullup,
    output logic [7:0] analog_ready,
    output logic external_irq_nine,
    output logic timer_capture_in0,
    output logic timer_capture_in1
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [31:0] awaddr;
        logic [7:0] wdata;
        logic wstb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] data;
        logic [7:0] oe;
        logic [7:0] fr2;
        logic [7:0] fr3;
        logic [7:0] pu;
        logic [7:0] ie;
    } ebio_state_t;

    ebio_state_t st;
    ebio_state_t nx;
    ebio_pkg::ebio_sel_t wsel;
    ebio_pkg::ebio_sel_t rsel;

    ebio_cfg_if cfg();

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------

    // write uses the held address, read the live one
    assign wsel = ebio_pkg::ebio_decode(st.awaddr);
    assign rsel = ebio_pkg::ebio_decode(s_axi_araddr);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------

    // bus slave and register file in one pass
    always_comb begin
        nx = st;
        // address and data are taken independently
        if (s_axi_awvalid && st.awready) begin
            nx.aw_got = 1'b1;
            nx.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            nx.w_got = 1'b1;
            nx.wdata = s_axi_wdata[7:0];
            nx.wstb = s_axi_wstrb[0];
        end
        // commit once both halves are held
        if (st.aw_got && st.w_got) begin
            nx.aw_got = 1'b0;
            nx.w_got = 1'b0;
            nx.bvalid = 1'b1;
            nx.bresp = ebio_pkg::RESP_OKAY;
            case (wsel)
                ebio_pkg::SEL_DATA: begin
                    if (st.wstb) begin
                        nx.data = st.wdata;
                    end
                end
                ebio_pkg::SEL_OE: begin
                    if (st.wstb) begin
                        nx.oe = st.wdata;
                    end
                end
                ebio_pkg::SEL_FR2: begin
                    if (st.wstb) begin
                        nx.fr2 = st.wdata & ebio_pkg::FR2_MASK;
                    end
                end
                ebio_pkg::SEL_FR3: begin
                    if (st.wstb) begin
                        nx.fr3 = st.wdata & ebio_pkg::FR3_MASK;
                    end
                end
                ebio_pkg::SEL_PU: begin
                    if (st.wstb) begin
                        nx.pu = st.wdata;
                    end
                end
                ebio_pkg::SEL_IE: begin
                    if (st.wstb) begin
                        nx.ie = st.wdata;
                    end
                end
                ebio_pkg::SEL_RSVD: begin
                    nx.bresp = ebio_pkg::RESP_SLVERR;
                end
                default: begin
                    nx.bresp = ebio_pkg::RESP_DECERR;
                end
            endcase
        end
        if (st.bvalid && s_axi_bready) begin
            nx.bvalid = 1'b0;
        end
        // read answers one cycle after the address is taken
        if (s_axi_arvalid && st.arready) begin
            nx.rvalid = 1'b1;
            nx.rresp = ebio_pkg::RESP_OKAY;
            nx.rdata = 8'h00;
            case (rsel)
                ebio_pkg::SEL_DATA: begin
                    nx.rdata = cfg.level;
                end
                ebio_pkg::SEL_OE: begin
                    nx.rdata = st.oe;
                end
                ebio_pkg::SEL_FR2: begin
                    nx.rdata = st.fr2;
                end
                ebio_pkg::SEL_FR3: begin
                    nx.rdata = st.fr3;
                end
                ebio_pkg::SEL_PU: begin
                    nx.rdata = st.pu;
                end
                ebio_pkg::SEL_IE: begin
                    nx.rdata = st.ie;
                end
                ebio_pkg::SEL_RSVD: begin
                    nx.rresp = ebio_pkg::RESP_SLVERR;
                end
                default: begin
                    nx.rresp = ebio_pkg::RESP_DECERR;
                end
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            nx.rvalid = 1'b0;
        end
        // one write and one read in flight at most
        nx.awready = !nx.aw_got && !nx.bvalid;
        nx.wready = !nx.w_got && !nx.bvalid;
        nx.arready = !nx.rvalid;
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st <= '0;
            st.data <= ebio_pkg::RST_DATA;
            st.oe <= ebio_pkg::RST_OE;
            st.fr2 <= ebio_pkg::RST_FR2;
            st.fr3 <= ebio_pkg::RST_FR3;
            st.pu <= ebio_pkg::RST_PU;
            st.ie <= ebio_pkg::RST_IE;
        end else begin
            st <= nx;
        end
    end

    // ------------------------------------------------------------
    // outputs and pin logic
    // ------------------------------------------------------------

    // bus outputs, upper data bits read as zero
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = {24'h000000, st.rdata};

    // configuration handed to the pin paths
    assign cfg.data = st.data;
    assign cfg.oe = st.oe;
    assign cfg.pu = st.pu;
    assign cfg.ie = st.ie;
    assign cfg.fr2 = st.fr2;
    assign cfg.fr3 = st.fr3;
    assign cfg.stop = stop_mode;

    // drivers and pull-ups
    ebio_pin_drive u_drive (
        .ref_clk(ref_clk),
        .reset(reset),
        .cfg(cfg.drive),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .pin_pullup(pin_pullup),
        .analog_ready(analog_ready)
    );

    // input buffers and routing
    ebio_pin_sense u_sense (
        .ref_clk(ref_clk),
        .reset(reset),
        .cfg(cfg.sense),
        .pin_in(pin_in),
        .external_irq_nine(external_irq_nine),
        .timer_capture_in0(timer_capture_in0),
        .timer_capture_in1(timer_capture_in1)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sequence wr_sel_s(ebio_pkg::ebio_sel_t sel);
        st.aw_got && st.w_got && wsel == sel;
    endsequence

    sequence rd_sel_s(ebio_pkg::ebio_sel_t sel);
        s_axi_arvalid && st.arready && rsel == sel;
    endsequence

    reset_clear_a: assert property (
        $fell(reset) |-> pin_oe == 8'h00 && pin_pullup == 8'h00
            && st.ie == 8'h00 && st.fr2 == 8'h00 && st.fr3 == 8'h00)
        else $error("port not idle after reset");

    data_write_a: assert property (
        wr_sel_s(ebio_pkg::SEL_DATA) ##0 st.wstb
        |=> st.data == $past(st.wdata) ##1 pin_out == $past(st.wdata, 2))
        else $error("data write not driven");

    oe_write_a: assert property (
        wr_sel_s(ebio_pkg::SEL_OE) ##0 st.wstb
        |=> ##1 pin_oe == $past(st.wdata, 2))
        else $error("output enable not applied");

    pu_write_a: assert property (
        wr_sel_s(ebio_pkg::SEL_PU) ##0 st.wstb
        |=> ##1 pin_pullup == $past(st.wdata, 2))
        else $error("pull-up not applied");

    fr_mask_a: assert property (
        (st.fr2 & ~ebio_pkg::FR2_MASK) == 8'h00
            && (st.fr3 & ~ebio_pkg::FR3_MASK) == 8'h00)
        else $error("unused select bit set");

    rsvd_resp_a: assert property (
        wr_sel_s(ebio_pkg::SEL_RSVD)
        |=> s_axi_bvalid && s_axi_bresp == ebio_pkg::RESP_SLVERR)
        else $error("reserved write not refused");

    irq_route_a: assert property (
        pin_in[7] && st.ie[7] && !stop_mode |=> external_irq_nine)
        else $error("enabled pin missed interrupt");

    timer_gate_a: assert property (
        !st.fr3[6] || !st.ie[6] |=> !timer_capture_in0)
        else $error("timer input without select");

    read_gate_a: assert property (
        rd_sel_s(ebio_pkg::SEL_DATA)
        |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(cfg.level)})
        else $error("data read not gated level");

    resp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");

endmodule

// ### verif/ebio_board_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// board side of the eight port pins
// ------------------------------------------------------------
module ebio_board_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_in
);
    // driven pins read back the port level, pulled pins sit high,
    // the rest follow whatever the board itself puts on them
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (pin_pullup[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = ext_level[i];
            end
        end
    end
endmodule

// ### verif/eight_bit_io_port_j_tb.sv
`timescale 1ns/1ps
module eight_bit_io_port_j_tb;
    // ------------------------------------------------------------
    // signals and register table
    // ------------------------------------------------------------
    localparam logic [5:0] OFFS [0:5] = '{ebio_pkg::OFF_DATA,
        ebio_pkg::OFF_OE, ebio_pkg::OFF_FR2, ebio_pkg::OFF_FR3,
        ebio_pkg::OFF_PU, ebio_pkg::OFF_IE};
    localparam logic [7:0] MASKS [0:5] = '{8'hFF, 8'hFF,
        ebio_pkg::FR2_MASK, ebio_pkg::FR3_MASK, 8'hFF, 8'hFF};
    logic ref_clk = 1'b0;
    logic reset, awvalid, wvalid, bready, arvalid, rready, stop_mode;
    logic awready, wready, bvalid, arready, rvalid, irq9, tin0, tin1;
    logic [31:0] awaddr, wdata, araddr, rdata, rnd_reg, rv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, analog_ready;
    logic [7:0] ext_level;
    logic [7:0] sh [0:5];
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    ebio_port_j dut (.ref_clk(ref_clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .stop_mode(stop_mode), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .analog_ready(analog_ready), .external_irq_nine(irq9),
        .timer_capture_in0(tin0), .timer_capture_in1(tin1));

    ebio_board_model board (.pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_level(ext_level), .pin_in(pin_in));

    // clock and hang guard
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // expected pad level seen by the port
    function automatic logic [7:0] level(input logic [7:0] d, oe, pu, e);
        return (oe & d) | (~oe & pu) | (~oe & ~pu & e);
    endfunction

    task automatic get_rnd(output logic [31:0] v);
        repeat (8) rnd_reg = lfsr_next(rnd_reg);
        v = rnd_reg;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask

    task automatic wr(input logic [31:0] a, d, input logic [3:0] s,
            output logic [1:0] r);
        logic ap, wp, bp, ta, tw, tb;
        ap = 1'b1;
        wp = 1'b1;
        bp = 1'b1;
        @(posedge ref_clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (bp) begin
            @(negedge ref_clk);
            ta = ap && awready;
            tw = wp && wready;
            tb = bvalid;
            if (tb) r = bresp;
            @(posedge ref_clk);
            if (ta) begin
                ap = 1'b0;
                awvalid <= 1'b0;
            end
            if (tw) begin
                wp = 1'b0;
                wvalid <= 1'b0;
            end
            if (tb) begin
                bp = 1'b0;
                bready <= 1'b0;
            end
        end
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d,
            output logic [1:0] r);
        logic ap, rp, ta, tr;
        ap = 1'b1;
        rp = 1'b1;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (rp) begin
            @(negedge ref_clk);
            ta = ap && arready;
            tr = rvalid;
            if (tr) begin
                d = rdata;
                r = rresp;
            end
            @(posedge ref_clk);
            if (ta) begin
                ap = 1'b0;
                arvalid <= 1'b0;
            end
            if (tr) begin
                rp = 1'b0;
                rready <= 1'b0;
            end
        end
    endtask

    task automatic set_reg(input int i, input logic [31:0] v);
        // only listed offsets, never a reserved one
        wr(ebio_pkg::BASE_ADDR + {26'h0, OFFS[i]}, v, 4'hF, rsp);
        chk("bresp", {30'h0, ebio_pkg::RESP_OKAY}, {30'h0, rsp});
        sh[i] = v[7:0] & MASKS[i];
    endtask

    task automatic rd_chk(input int i, input logic [31:0] e);
        rd(ebio_pkg::BASE_ADDR + {26'h0, OFFS[i]}, rv, rsp);
        chk("rresp", {30'h0, ebio_pkg::RESP_OKAY}, {30'h0, rsp});
        chk("rdata", e, rv);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, stop_mode} = 6'h00;
        {awaddr, wdata, araddr} = {3{32'h0}};
        wstrb = 4'h0;
        ext_level = 8'h00;
        rnd_reg = 32'h0000005A;
        reset = 1'b1;
        for (int i = 0; i < 6; i++) sh[i] = 8'h00;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        // reset state of pins and registers
        chk("pin_oe", 32'h0, {24'h0, pin_oe});
        chk("pin_pullup", 32'h0, {24'h0, pin_pullup});
        chk("analog_ready", 32'hFF, {24'h0, analog_ready});
        for (int i = 0; i < 6; i++) rd_chk(i, 32'h0);
        $display("test reset done");
        // random register writes, upper bits must read zero
        for (int n = 0; n < 4; n++) begin
            for (int i = 1; i < 6; i++) begin
                get_rnd(rv);
                // pin 7 never selected in both select registers
                if ((i == 2 && sh[3][7]) || (i == 3 && sh[2][7]))
                    rv[7] = 1'b0;
                set_reg(i, rv);
                rd_chk(i, {24'h0, sh[i]});
            end
            repeat (2) @(posedge ref_clk);
            chk("pin_oe", {24'h0, sh[1]}, {24'h0, pin_oe});
            chk("pin_pullup", {24'h0, sh[4]}, {24'h0, pin_pullup});
            chk("analog_ready", {24'h0, ~(sh[4] | sh[5])},
                {24'h0, analog_ready});
        end
        set_reg(2, 32'h0);
        set_reg(3, 32'h0);
        $display("test registers done");
        // data path with mixed directions
        for (int n = 0; n < 8; n++) begin
            get_rnd(rv);
            ext_level <= rv[15:8];
            set_reg(1, {24'h0, rv[23:16]});
            set_reg(4, {24'h0, rv[31:24]});
            set_reg(5, {24'h0, rv[7:0] | 8'h0F});
            get_rnd(rv);
            set_reg(0, rv);
            repeat (2) @(posedge ref_clk);
            chk("pin_out", {24'h0, sh[0]}, {24'h0, pin_out});
            rd_chk(0, {24'h0, level(sh[0], sh[1], sh[4], ext_level)
                & sh[5]});
        end
        $display("test data done");
        // reserved, outside and masked accesses
        for (logic [5:0] o = 6'h08; o < 6'h38; o += 6'h04) begin
            if (o == 6'h0C || o == 6'h10 || o == 6'h2C) continue;
            wr(ebio_pkg::BASE_ADDR + {26'h0, o}, 32'hFF, 4'hF, rsp);
            chk("bresp", {30'h0, ebio_pkg::RESP_SLVERR},
                {30'h0, rsp});
            rd(ebio_pkg::BASE_ADDR + {26'h0, o}, rv, rsp);
            chk("rresp", {30'h0, ebio_pkg::RESP_SLVERR},
                {30'h0, rsp});
            chk("rdata", 32'h0, rv);
        end
        wr(32'h400C_0A04, 32'hFF, 4'hF, rsp);
        chk("bresp", {30'h0, ebio_pkg::RESP_DECERR}, {30'h0, rsp});
        rd(32'h400C_0A04, rv, rsp);
        chk("rresp", {30'h0, ebio_pkg::RESP_DECERR}, {30'h0, rsp});
        // lane 0 strobe low: write ignored but still answered okay
        wr(ebio_pkg::BASE_ADDR + 32'h4, ~{24'h0, sh[1]}, 4'hE, rsp);
        chk("bresp", {30'h0, ebio_pkg::RESP_OKAY}, {30'h0, rsp});
        rd_chk(1, {24'h0, sh[1]});
        $display("test refused done");
        // interrupt routing in and out of stop mode
        set_reg(1, 32'h0);
        set_reg(4, 32'h0);
        set_reg(5, 32'h80);
        ext_level <= 8'h80;
        repeat (3) @(posedge ref_clk);
        chk("irq", 32'h1, {31'h0, irq9});
        stop_mode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("irq", 32'h0, {31'h0, irq9});
        set_reg(2, 32'h80);
        repeat (3) @(posedge ref_clk);
        chk("irq", 32'h1, {31'h0, irq9});
        set_reg(2, 32'h0);
        stop_mode <= 1'b0;
        $display("test interrupt done");
        // timer capture routing
        set_reg(3, 32'hC0);
        set_reg(5, 32'hC0);
        ext_level <= 8'h40;
        repeat (3) @(posedge ref_clk);
        chk("tin0", 32'h1, {31'h0, tin0});
        chk("tin1", 32'h0, {31'h0, tin1});
        ext_level <= 8'h80;
        repeat (3) @(posedge ref_clk);
        chk("tin1", 32'h1, {31'h0, tin1});
        chk("irq", 32'h1, {31'h0, irq9});
        set_reg(3, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk("tin1", 32'h0, {31'h0, tin1});
        // analog use with input and pull-up off
        set_reg(5, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk("analog_ready", 32'hFF, {24'h0, analog_ready});
        $display("test routing done");
        results();
    end
endmodule
